// ---- rtl/uec_endpoint_ctrl.sv ----
// Endpoint 0 control and endpoint 1 receive register logic.
// Assumes a serial engine on mclk that posts one-cycle transaction events.
`default_nettype none
//
// Behaviour
// RL1: SETUP on endpoint 0 sets tx toggle.
// RL2: Tx toggle flips only after host ACK.
// RL3: Software may write both toggle bits.
// RL4: Endpoint 0 tx status decode, bits 5:4.
// RL5: Endpoint 0 rx status decode, bits 1:0.
// RL6: Endpoint 0 done forces both statuses NAK.
// RL7: Setup stage clears endpoint 0 rx toggle.
// RL8: Rx toggle flips on matching good packet.
// RL9: SETUP while enabled: acknowledge, both NAK.
// RL10: Endpoint 0 STALL sets both statuses STALL.
// RL11: Link reset clears endpoint 1 bits 2:0.
// RL12: Reserved bits always read zero.
// RL13: Endpoint 1 done flag set, software clears.
// RL14: Endpoint 1 rx status decode, bits 1:0.
// RL15: Endpoint 1 done sets only rx NAK.
// RL16: Endpoint 0 done flag set, software clears.
// RL17: Link reset clears endpoint 0 bits 6:4, 2:0.
// RL18: Done flags raise shared transfer interrupt.

module uec_endpoint_ctrl (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // Register port
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // Link side
  input  wire logic               bus_link_reset,
  input  wire uec_pkg::uec_evt_t  evt,
  output uec_pkg::uec_epst_t      ep_state,
  output logic                    ep0_answer_setup,
  output logic                    irq
);
  import uec_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       ep0_done_flag_reg, ep0_done_flag_next;
  logic       ep0_tx_tog_reg,    ep0_tx_tog_next;
  uec_stat_t  ep0_tx_stat_reg,   ep0_tx_stat_next;
  logic       ep0_rx_tog_reg,    ep0_rx_tog_next;
  uec_stat_t  ep0_rx_stat_reg,   ep0_rx_stat_next;
  logic       rx_done_flag_reg,  rx_done_flag_next;
  logic       ep1_rx_tog_reg,    ep1_rx_tog_next;
  uec_stat_t  ep1_rx_stat_reg,   ep1_rx_stat_next;
  logic       force_link_reset_reg, force_link_reset_next;
  logic [1:0] istat_reg, istat_next;
  logic [1:0] imask_reg, imask_next;
  logic [2:0] xstat_reg, xstat_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       lrst_prev_reg, lrst_prev_next;
  logic       bus_rst_s1_reg, bus_rst_s2_reg;

  logic       link_rst, ev0, ev1, wr_ep0, wr_ep1;
  logic       ep0_tx_en, ep0_rx_en, ep1_rx_en;
  logic       set_xfer, set_lrst;
  logic [7:0] ep0_view, ep1_view;

  // Bus reset comes from the pin domain, two flops before use.
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_rst_s1_reg <= 1'b0;
      bus_rst_s2_reg <= 1'b0;
    end else begin
      bus_rst_s1_reg <= bus_link_reset;
      bus_rst_s2_reg <= bus_rst_s1_reg;
    end
  end

  // Held in reset for as long as software keeps the force bit set.
  assign link_rst = bus_rst_s2_reg | force_link_reset_reg;
  assign ev0      = evt.valid & ~evt.ep1;
  assign ev1      = evt.valid &  evt.ep1;
  assign wr_ep0   = reg_wr && reg_addr == UEC_ADDR_EP0;
  assign wr_ep1   = reg_wr && reg_addr == UEC_ADDR_EP1RX;

  // ----------------------------------------------------------------
  // Status decode
  // ----------------------------------------------------------------
  assign ep0_tx_en = ep0_tx_stat_reg != UEC_ST_DIS;                   // RL4
  assign ep0_rx_en = ep0_rx_stat_reg != UEC_ST_DIS;                   // RL5
  assign ep1_rx_en = ep1_rx_stat_reg != UEC_ST_DIS;                   // RL14
  // A SETUP is taken whenever the endpoint is not wholly disabled.
  assign ep0_answer_setup = ep0_tx_en | ep0_rx_en;                    // RL9

  assign ep_state.ep0_tx_stat = ep0_tx_stat_reg;                      // RL4
  assign ep_state.ep0_rx_stat = ep0_rx_stat_reg;                      // RL5
  assign ep_state.ep0_tx_tog  = ep0_tx_tog_reg;
  assign ep_state.ep0_rx_tog  = ep0_rx_tog_reg;
  assign ep_state.ep1_rx_stat = ep1_rx_stat_reg;                      // RL14
  assign ep_state.ep1_rx_tog  = ep1_rx_tog_reg;

  // ----------------------------------------------------------------
  // Endpoint 0
  // ----------------------------------------------------------------
  always_comb begin
    ep0_done_flag_next = ep0_done_flag_reg;
    ep0_tx_tog_next    = ep0_tx_tog_reg;
    ep0_tx_stat_next   = ep0_tx_stat_reg;
    ep0_rx_tog_next    = ep0_rx_tog_reg;
    ep0_rx_stat_next   = ep0_rx_stat_reg;
    if (wr_ep0) begin
      ep0_tx_tog_next  = reg_wdata[UEC_EP0_TXTOG];                   // RL3
      ep0_tx_stat_next = uec_stat_t'(reg_wdata[5:4]);
      ep0_rx_tog_next  = reg_wdata[UEC_RXTOG];                       // RL3
      ep0_rx_stat_next = uec_stat_t'(reg_wdata[1:0]);
      if (!reg_wdata[UEC_EP0_DONE_BIT]) begin
        ep0_done_flag_next = 1'b0;                                    // RL16
      end
    end
    if (ev0) begin
      if (evt.stall_sent) begin
        ep0_tx_stat_next = UEC_ST_STALL;                              // RL10
        ep0_rx_stat_next = UEC_ST_STALL;                              // RL10
      end else if (evt.token == UEC_TOK_SETUP && ep0_answer_setup) begin
        ep0_tx_tog_next    = 1'b1;                                    // RL1
        ep0_rx_tog_next    = 1'b0;                                    // RL7
        ep0_tx_stat_next   = UEC_ST_NAK;                              // RL9
        ep0_rx_stat_next   = UEC_ST_NAK;                              // RL9
        ep0_done_flag_next = 1'b1;                                    // RL16
      end else if (evt.token == UEC_TOK_IN && ep0_tx_stat_reg == UEC_ST_VALID) begin
        if (evt.ack_rx) begin
          ep0_tx_tog_next    = ~ep0_tx_tog_reg;                       // RL2
          ep0_done_flag_next = 1'b1;                                  // RL16
          ep0_tx_stat_next   = UEC_ST_NAK;                            // RL6
          ep0_rx_stat_next   = UEC_ST_NAK;                            // RL6
        end
      end else if (evt.token == UEC_TOK_OUT && ep0_rx_stat_reg == UEC_ST_VALID) begin
        if (evt.data_ok && evt.data_pid1 == ep0_rx_tog_reg) begin
          ep0_rx_tog_next    = ~ep0_rx_tog_reg;                       // RL8
          ep0_done_flag_next = 1'b1;                                  // RL16
          ep0_tx_stat_next   = UEC_ST_NAK;                            // RL6
          ep0_rx_stat_next   = UEC_ST_NAK;                            // RL6
        end
      end
    end
    if (link_rst) begin
      ep0_tx_tog_next  = 1'b0;                                        // RL17
      ep0_tx_stat_next = UEC_ST_DIS;                                  // RL17
      ep0_rx_tog_next  = 1'b0;                                        // RL17
      ep0_rx_stat_next = UEC_ST_DIS;                                  // RL17
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 1 receive
  // ----------------------------------------------------------------
  always_comb begin
    rx_done_flag_next = rx_done_flag_reg;
    ep1_rx_tog_next   = ep1_rx_tog_reg;
    ep1_rx_stat_next  = ep1_rx_stat_reg;
    if (wr_ep1) begin
      ep1_rx_tog_next  = reg_wdata[UEC_RXTOG];                       // RL3
      ep1_rx_stat_next = uec_stat_t'(reg_wdata[1:0]);
      if (!reg_wdata[UEC_EP1_DONE_BIT]) begin
        rx_done_flag_next = 1'b0;                                     // RL13
      end
    end
    if (ev1 && evt.token == UEC_TOK_OUT && ep1_rx_en) begin
      if (ep1_rx_stat_reg == UEC_ST_VALID && evt.data_ok &&
          evt.data_pid1 == ep1_rx_tog_reg) begin
        ep1_rx_tog_next   = ~ep1_rx_tog_reg;                          // RL8
        rx_done_flag_next = 1'b1;                                     // RL13
        ep1_rx_stat_next  = UEC_ST_NAK;                               // RL15
      end
    end
    if (link_rst) begin
      ep1_rx_tog_next  = 1'b0;                                        // RL11
      ep1_rx_stat_next = UEC_ST_DIS;                                  // RL11
    end
  end

  // ----------------------------------------------------------------
  // Link control, interrupts, read port
  // ----------------------------------------------------------------
  assign set_xfer = (ep0_done_flag_next & ~ep0_done_flag_reg) |
                    (rx_done_flag_next & ~rx_done_flag_reg);          // RL18
  // The link-reset event is raised when the held reset ends.
  assign set_lrst = lrst_prev_reg & ~link_rst;
  assign ep0_view = {ep0_done_flag_reg, ep0_tx_tog_reg, ep0_tx_stat_reg,
                     1'b0, ep0_rx_tog_reg, ep0_rx_stat_reg};          // RL12
  assign ep1_view = {4'h0, rx_done_flag_reg, ep1_rx_tog_reg,
                     ep1_rx_stat_reg};                                // RL12

  always_comb begin
    force_link_reset_next = force_link_reset_reg;
    imask_next            = imask_reg;
    istat_next            = istat_reg;
    xstat_next            = xstat_reg;
    lrst_prev_next        = link_rst;
    rdata_next            = UEC_RESET_VAL;
    if (reg_wr && reg_addr == UEC_ADDR_LINK) begin
      force_link_reset_next = reg_wdata[UEC_LINK_FORCE_LINK_RESET];
    end
    if (reg_wr && reg_addr == UEC_ADDR_IMASK) begin
      imask_next = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == UEC_ADDR_ISTAT) begin
      istat_next = istat_reg & ~reg_wdata[1:0];
    end
    // Setting wins over a clear in the same cycle.
    if (set_xfer) begin
      istat_next[UEC_IRQ_XFER] = 1'b1;                                // RL18
      xstat_next = {evt.ep1, evt.token};                              // RL18
    end
    if (set_lrst) begin
      istat_next[UEC_IRQ_LRST] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        UEC_ADDR_EP0:   rdata_next = ep0_view;
        UEC_ADDR_EP1RX: rdata_next = ep1_view;
        UEC_ADDR_LINK:  rdata_next = {7'h00, force_link_reset_reg};
        UEC_ADDR_ISTAT: rdata_next = {6'h00, istat_reg};
        UEC_ADDR_IMASK: rdata_next = {6'h00, imask_reg};
        UEC_ADDR_XSTAT: rdata_next = {5'h00, xstat_reg};
        default:        rdata_next = UEC_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ep0_done_flag_reg    <= 1'b0;
      ep0_tx_tog_reg       <= 1'b0;
      ep0_tx_stat_reg      <= UEC_ST_DIS;
      ep0_rx_tog_reg       <= 1'b0;
      ep0_rx_stat_reg      <= UEC_ST_DIS;
      rx_done_flag_reg     <= 1'b0;
      ep1_rx_tog_reg       <= 1'b0;
      ep1_rx_stat_reg      <= UEC_ST_DIS;
      force_link_reset_reg <= 1'b0;
      istat_reg            <= 2'h0;
      imask_reg            <= 2'h0;
      xstat_reg            <= 3'h0;
      rdata_reg            <= UEC_RESET_VAL;
      lrst_prev_reg        <= 1'b0;
    end else begin
      ep0_done_flag_reg    <= ep0_done_flag_next;
      ep0_tx_tog_reg       <= ep0_tx_tog_next;
      ep0_tx_stat_reg      <= ep0_tx_stat_next;
      ep0_rx_tog_reg       <= ep0_rx_tog_next;
      ep0_rx_stat_reg      <= ep0_rx_stat_next;
      rx_done_flag_reg     <= rx_done_flag_next;
      ep1_rx_tog_reg       <= ep1_rx_tog_next;
      ep1_rx_stat_reg      <= ep1_rx_stat_next;
      force_link_reset_reg <= force_link_reset_next;
      istat_reg            <= istat_next;
      imask_reg            <= imask_next;
      xstat_reg            <= xstat_next;
      rdata_reg            <= rdata_next;
      lrst_prev_reg        <= lrst_prev_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(istat_reg & imask_reg);

endmodule : uec_endpoint_ctrl

`default_nettype wire

// ---- rtl/uec_pkg.sv ----
// Package for the endpoint 0 / endpoint 1 receive control block.
// Assumes one clock domain and a plain register port with 8-bit data.
`default_nettype none

package uec_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] UEC_ADDR_EP0   = 3'h0;
  localparam logic [2:0] UEC_ADDR_EP1RX = 3'h1;
  localparam logic [2:0] UEC_ADDR_LINK  = 3'h2;
  localparam logic [2:0] UEC_ADDR_ISTAT = 3'h3;
  localparam logic [2:0] UEC_ADDR_IMASK = 3'h4;
  localparam logic [2:0] UEC_ADDR_XSTAT = 3'h5;

  localparam logic [7:0] UEC_RESET_VAL  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UEC_EP0_DONE_BIT = 7;
  localparam int UEC_EP0_TXTOG    = 6;
  localparam int UEC_EP1_DONE_BIT = 3;
  localparam int UEC_RXTOG        = 2;
  localparam int UEC_LINK_FORCE_LINK_RESET    = 0;
  localparam int UEC_IRQ_XFER     = 0;
  localparam int UEC_IRQ_LRST     = 1;

  // ----------------------------------------------------------------
  // Status codes and token kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UEC_ST_DIS   = 2'h0,
    UEC_ST_STALL = 2'h1,
    UEC_ST_NAK   = 2'h2,
    UEC_ST_VALID = 2'h3
  } uec_stat_t;

  typedef enum logic [1:0] {
    UEC_TOK_OUT   = 2'h0,
    UEC_TOK_IN    = 2'h2,
    UEC_TOK_SETUP = 2'h3
  } uec_tok_t;

  // Transaction outcome reported by the serial engine, one-cycle valid.
  typedef struct packed {
    logic       valid;
    logic       ep1;
    uec_tok_t   token;
    logic       data_ok;
    logic       data_pid1;
    logic       ack_rx;
    logic       stall_sent;
  } uec_evt_t;

  // Endpoint answers toward the serial engine.
  typedef struct packed {
    uec_stat_t ep0_tx_stat;
    uec_stat_t ep0_rx_stat;
    logic      ep0_tx_tog;
    logic      ep0_rx_tog;
    uec_stat_t ep1_rx_stat;
    logic      ep1_rx_tog;
  } uec_epst_t;

endpackage : uec_pkg

`default_nettype wire

// ---- tb/uec_checker.sv ----
// Assertions on the ports of the endpoint control block.
// Assumes no transaction event is posted while a link reset is active.
`default_nettype none
module uec_checker
  import uec_pkg::*;
(
  // Clock and reset
  input wire logic      mclk,
  input wire logic      reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic      reg_wr,
  input wire logic      reg_rd,
  input wire logic [7:0] reg_rdata,
  // Link side
  input wire uec_evt_t  evt,
  input wire uec_epst_t ep_state,
  input wire logic      ep0_answer_setup
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic e0;
  logic nak2;
  assign e0   = evt.valid && !evt.ep1 && !evt.stall_sent;
  assign nak2 = ep_state.ep0_tx_stat == UEC_ST_NAK && ep_state.ep0_rx_stat == UEC_ST_NAK;
  a_setup_load: assert property (e0 && evt.token == UEC_TOK_SETUP && ep0_answer_setup |=>
    ep_state.ep0_tx_tog && !ep_state.ep0_rx_tog && nak2) else $error("setup load wrong");
  a_stall_both: assert property (evt.valid && !evt.ep1 && evt.stall_sent |=>
    ep_state.ep0_tx_stat == UEC_ST_STALL && ep_state.ep0_rx_stat == UEC_ST_STALL)
    else $error("stall not on both");
  a_in_ack_flip: assert property (e0 && evt.token == UEC_TOK_IN && evt.ack_rx &&
    ep_state.ep0_tx_stat == UEC_ST_VALID |=> nak2 &&
    ep_state.ep0_tx_tog != $past(ep_state.ep0_tx_tog)) else $error("tx toggle kept");
  a_in_nack_hold: assert property (e0 && evt.token == UEC_TOK_IN && !evt.ack_rx && !reg_wr
    |=> $stable(ep_state.ep0_tx_tog)) else $error("tx toggle moved");
  a_rx_match_flip: assert property (e0 && evt.token == UEC_TOK_OUT && evt.data_ok &&
    evt.data_pid1 == ep_state.ep0_rx_tog && ep_state.ep0_rx_stat == UEC_ST_VALID |=>
    nak2 && ep_state.ep0_rx_tog != $past(ep_state.ep0_rx_tog)) else $error("rx toggle kept");
  a_rx_bad_hold: assert property (e0 && evt.token == UEC_TOK_OUT && !reg_wr &&
    (!evt.data_ok || evt.data_pid1 != ep_state.ep0_rx_tog) |=> $stable(ep_state.ep0_rx_tog))
    else $error("rx toggle moved");
  a_ep1_nak_only: assert property (evt.valid && evt.ep1 && evt.token == UEC_TOK_OUT &&
    evt.data_ok && !reg_wr &&
    evt.data_pid1 == ep_state.ep1_rx_tog && ep_state.ep1_rx_stat == UEC_ST_VALID |=>
    ep_state.ep1_rx_stat == UEC_ST_NAK && $stable(ep_state.ep0_tx_stat))
    else $error("ep1 status wrong");
  a_rsv_zero: assert property (reg_rd && reg_addr == UEC_ADDR_EP1RX |=>
    reg_rdata[7:4] == 4'h0) else $error("reserved bits set");
  a_ep0_view: assert property (reg_rd && reg_addr == UEC_ADDR_EP0 |=>
    reg_rdata[6:0] == {$past(ep_state.ep0_tx_tog), $past(ep_state.ep0_tx_stat), 1'b0,
    $past(ep_state.ep0_rx_tog), $past(ep_state.ep0_rx_stat)}) else $error("ep0 view wrong");
  a_answer_lvl: assert property (ep0_answer_setup ==
    (ep_state.ep0_tx_stat != UEC_ST_DIS || ep_state.ep0_rx_stat != UEC_ST_DIS))
    else $error("setup answer wrong");
endmodule : uec_checker
bind uec_endpoint_ctrl uec_checker uec_checker_i (.mclk, .reset, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .evt, .ep_state, .ep0_answer_setup);
`default_nettype wire

// ---- tb/uec_host_model.sv ----
// Host and serial engine model that turns bench requests into outcomes.
// Assumes one request per cycle on mclk.
`default_nettype none
module uec_host_model
  import uec_pkg::*;
(
  // Clock
  input  wire logic      mclk,
  // Request and endpoint state
  input  wire uec_evt_t  req,
  input  wire uec_epst_t ep_state,
  // Outcome
  output var  uec_evt_t  evt
);
  uec_stat_t st;
  always_comb begin
    st = req.ep1 ? ep_state.ep1_rx_stat :
         (req.token == UEC_TOK_IN) ? ep_state.ep0_tx_stat : ep_state.ep0_rx_stat;
  end
  // Data only goes out on a valid endpoint, so the host can only ACK then.
  always_ff @(posedge mclk) begin
    evt            <= req;
    evt.stall_sent <= req.token != UEC_TOK_SETUP && st == UEC_ST_STALL;
    evt.ack_rx     <= req.ack_rx && st == UEC_ST_VALID;
  end
endmodule : uec_host_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the endpoint control block.
// Assumes the host model drives the event port.
`default_nettype none
module testbench;
  import uec_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk, reset, reg_wr, reg_rd, bus_link_reset, ep0_answer_setup, irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] s;
  uec_evt_t   req, evt;
  uec_epst_t  ep_state;
  int         fails, cmp_count;
  uec_endpoint_ctrl uec_endpoint_ctrl_i (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bus_link_reset, .evt, .ep_state, .ep0_answer_setup, .irq);
  uec_host_model uec_host_model_i (.mclk, .req, .ep_state, .evt);
  always #2 mclk = ~mclk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk($sformatf("register %0d", a), e, reg_rdata);
  endtask : rd
  task automatic ev(input logic e1, input uec_tok_t t, input logic ok, input logic p,
                    input logic ack);
    @(posedge mclk);
    req <= '{1'b1, e1, t, ok, p, ack, 1'b0};
    @(posedge mclk);
    req.valid <= 1'b0;
    @(posedge mclk);
  endtask : ev
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    #20000;
    fails++;
    stop_test();
  end
  initial begin
    mclk = 0; reset = 1; reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0;
    bus_link_reset = 0; req = '0; fails = 0; cmp_count = 0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(UEC_ADDR_EP0, 8'h00);
    rd(UEC_ADDR_EP1RX, 8'h00);
    rd(3'h7, 8'h00);
    ev(1'b0, UEC_TOK_SETUP, 1'b1, 1'b0, 1'b0);
    rd(UEC_ADDR_EP0, 8'h00);
    wr(UEC_ADDR_EP0, 8'hFF);
    rd(UEC_ADDR_EP0, 8'h77);
    wr(UEC_ADDR_EP1RX, 8'hFF);
    rd(UEC_ADDR_EP1RX, 8'h07);
    wr(UEC_ADDR_IMASK, 8'h01);
    ev(1'b0, UEC_TOK_SETUP, 1'b1, 1'b1, 1'b0);
    rd(UEC_ADDR_EP0, 8'hE2);
    rd(UEC_ADDR_XSTAT, 8'h03);
    rd(UEC_ADDR_ISTAT, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    wr(UEC_ADDR_ISTAT, 8'h01);
    #1 chk("irq", 8'h00, {7'h0, irq});
    wr(UEC_ADDR_IMASK, 8'h00);
    for (s = 0; s < 4; s++) begin
      wr(UEC_ADDR_EP0, {2'b00, s[1:0], 4'h3});
      ev(1'b0, UEC_TOK_IN, 1'b1, 1'b0, 1'b1);
      rd(UEC_ADDR_EP0, s == 1 ? 8'h11 : s == 3 ? 8'hE2 : {2'b00, s[1:0], 4'h3});
      wr(UEC_ADDR_EP0, {6'h00, s[1:0]});
      ev(1'b0, UEC_TOK_OUT, 1'b1, 1'b0, 1'b0);
      rd(UEC_ADDR_EP0, s == 1 ? 8'h11 : s == 3 ? 8'hA6 : {6'h00, s[1:0]});
      wr(UEC_ADDR_EP1RX, {6'h00, s[1:0]});
      ev(1'b1, UEC_TOK_OUT, 1'b1, 1'b0, 1'b0);
      rd(UEC_ADDR_EP1RX, s == 3 ? 8'h0E : {6'h00, s[1:0]});
    end
    chk("irq", 8'h00, {7'h0, irq});
    rd(UEC_ADDR_ISTAT, 8'h01);
    wr(UEC_ADDR_EP0, 8'h37);
    ev(1'b0, UEC_TOK_OUT, 1'b1, 1'b0, 1'b0);
    ev(1'b0, UEC_TOK_OUT, 1'b0, 1'b1, 1'b0);
    ev(1'b0, UEC_TOK_IN, 1'b1, 1'b0, 1'b0);
    rd(UEC_ADDR_EP0, 8'h37);
    ev(1'b0, UEC_TOK_OUT, 1'b1, 1'b1, 1'b0);
    rd(UEC_ADDR_EP0, 8'hA2);
    // Long enough to pass the two-flop synchroniser on both edges.
    bus_link_reset <= 1'b1;
    repeat (6) @(posedge mclk);
    bus_link_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(UEC_ADDR_EP1RX, 8'h08);
    rd(UEC_ADDR_EP0, 8'h80);
    wr(UEC_ADDR_EP0, 8'hB7);
    wr(UEC_ADDR_LINK, 8'h01);
    wr(UEC_ADDR_LINK, 8'h00);
    rd(UEC_ADDR_EP0, 8'h80);
    wr(UEC_ADDR_EP1RX, 8'h00);
    rd(UEC_ADDR_EP1RX, 8'h00);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
